// ### rtl/wdt_consts.svh
// constants of the windowed watchdog: register offsets, field positions, reset values
// assumes inclusion by the watchdog package and the watchdog top module only
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_ADDR_W 12
`define WDT_OFS_CONFIG 12'h000
`define WDT_OFS_RESET_CTRL 12'h004
`define WDT_OFS_CLK_SEL 12'h008
`define WDT_OFS_COUNT 12'h00c
`define WDT_CFG_RESET 8'hff
`define WDT_CFG_POST_LO 0
`define WDT_CFG_PRESC_BIT 4
`define WDT_CFG_EN_LO 5
`define WDT_CFG_WINDOW_DISABLE_BIT_BIT 7
`define WDT_RC_IDLE_BIT 2
`define WDT_RC_SLEEP_BIT 3
`define WDT_RC_FLAG_BIT 4
`define WDT_RC_SWEN_BIT 5
`define WDT_EN_ALWAYS 2'h3
`define WDT_EN_SOFT 2'h2
`define WDT_PRESC_SHORT 23'h000020
`define WDT_PRESC_LONG 23'h000080
`define WDT_CNT_W 23
`define WDT_SRC_CLK_KHZ 32
`define WDT_BASE_SHORT_MS 1
`define WDT_BASE_LONG_MS 4
`endif

// ### rtl/wdt_pkg.sv
// types of the windowed watchdog
// assumes the constants header is on the include path
`include "wdt_consts.svh"
package wdt_pkg;
    typedef enum logic [1:0] {src_low_power_rc_osc, src_secondary_osc, src_systimer} clk_src_t;
    typedef enum logic [1:0] {pm_run, pm_idle, pm_sleep} power_state_t;
    // one-cycle pulses from the processor core, all on pclk
    typedef struct packed {
        logic clear_counter_instr;
        logic power_save_instr;
        logic save_to_sleep;
        logic wake_event;
        logic clock_switch_done;
        logic device_reset;
    } core_events_t;
    typedef struct packed {
        logic low_power_rc_osc;
        logic secondary_osc;
        logic system_timer;
    } wdt_clocks_t;
endpackage

// ### rtl/windowed_watchdog_timer.sv
// windowed watchdog timer with apb register access
// assumes core event pulses on pclk and slow source clocks arriving as raw pins
`timescale 1ns/1ps
`include "wdt_consts.svh"
module windowed_watchdog_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`WDT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire wdt_pkg::core_events_t core_events,
    input wire wdt_pkg::wdt_clocks_t src_clocks,
    output logic low_power_rc_osc_enable,
    output logic secondary_osc_enable,
    output logic system_timer_enable,
    output logic watchdog_reset,
    output logic watchdog_wake,
    output logic sleep_active,
    output logic idle_active
);
    // time-out period in source clocks for prescaler mode and postscale code
    function automatic logic [`WDT_CNT_W-1:0] period_of(input logic presc_long,
                                                      input logic [3:0] post_code);
        logic [`WDT_CNT_W-1:0] base;
        base = presc_long ? `WDT_PRESC_LONG : `WDT_PRESC_SHORT;
        return base << post_code;
    endfunction

    logic [7:0] watchdog_config_word;
    logic soft_enable_bit;
    logic timeout_flag;
    logic sleep_status;
    logic idle_status;
    wdt_pkg::clk_src_t clk_select;
    wdt_pkg::power_state_t power_state;
    logic [`WDT_CNT_W-1:0] count;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic tick_prev;

    logic [3:0] postscale_select_field;
    logic prescale_select_bit;
    logic [1:0] enable_config_field;
    logic window_disable_bit;
    logic enabled;
    wdt_pkg::clk_src_t active_src;
    logic src_level;
    logic tick;
    logic [`WDT_CNT_W-1:0] period;
    logic window_open;
    logic terminal;
    logic timeout;
    logic any_dev_reset;
    logic in_save;
    logic good_clear;
    logic early_clear;
    logic leave_save;
    logic enter_save;
    logic counter_clear;
    logic wr_access;
    logic rd_setup;

    assign postscale_select_field = watchdog_config_word[`WDT_CFG_POST_LO +: 4];
    assign prescale_select_bit = watchdog_config_word[`WDT_CFG_PRESC_BIT];
    assign enable_config_field = watchdog_config_word[`WDT_CFG_EN_LO +: 2];
    assign window_disable_bit = watchdog_config_word[`WDT_CFG_WINDOW_DISABLE_BIT_BIT];

    // enable decode: always on, software controlled, or off
    assign enabled = (enable_config_field == `WDT_EN_ALWAYS) ||
                     ((enable_config_field == `WDT_EN_SOFT) && soft_enable_bit);

    // sleep forces the rc oscillator as counter clock
    assign active_src = (power_state == wdt_pkg::pm_sleep) ? wdt_pkg::src_low_power_rc_osc : clk_select;

    // two-flop synchronisers for the three source clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {src_clocks.system_timer, src_clocks.secondary_osc,
                       src_clocks.low_power_rc_osc};
            sync_b <= sync_a;
        end
    end

    always_comb begin
        case (active_src)
            wdt_pkg::src_secondary_osc: src_level = sync_b[1];
            wdt_pkg::src_systimer: src_level = sync_b[2];
            default: src_level = sync_b[0];
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= src_level;
        end
    end

    assign tick = src_level && !tick_prev;

    // period is prescale (32 or 128) times 2^n; window is its last quarter
    assign period = period_of(prescale_select_bit, postscale_select_field);
    assign window_open = count >= (period - (period >> 2));
    assign terminal = count == (period - `WDT_CNT_W'(1));
    assign timeout = enabled && tick && terminal;

    assign any_dev_reset = core_events.device_reset || watchdog_reset;
    assign in_save = power_state != wdt_pkg::pm_run;
    assign good_clear = core_events.clear_counter_instr && !in_save &&
                        (window_disable_bit || window_open);
    assign early_clear = core_events.clear_counter_instr && !in_save && enabled &&
                         !window_disable_bit && !window_open;
    assign enter_save = core_events.power_save_instr && !in_save;
    assign leave_save = in_save && (core_events.wake_event || timeout);
    assign counter_clear = any_dev_reset || core_events.clock_switch_done ||
                           enter_save || leave_save || good_clear;

    // combined prescaler and postscaler count, running in sleep and idle too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (counter_clear) begin
            count <= '0;
        end else if (enabled && tick) begin
            count <= terminal ? '0 : count + `WDT_CNT_W'(1);
        end
    end

    // power-save state tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_state <= wdt_pkg::pm_run;
        end else if (core_events.device_reset) begin
            power_state <= wdt_pkg::pm_run;
        end else if (enter_save) begin
            power_state <= core_events.save_to_sleep ? wdt_pkg::pm_sleep : wdt_pkg::pm_idle;
        end else if (leave_save) begin
            power_state <= wdt_pkg::pm_run;
        end
    end

    // time-out outcome: wake in power-save, reset in normal run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset <= 1'b0;
            watchdog_wake <= 1'b0;
        end else begin
            watchdog_reset <= (timeout && !in_save) || early_clear;
            watchdog_wake <= timeout && in_save;
        end
    end

    // the active source's enable follows the enable state; the other two stay off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_power_rc_osc_enable <= 1'b0;
            secondary_osc_enable <= 1'b0;
            system_timer_enable <= 1'b0;
        end else begin
            low_power_rc_osc_enable <= enabled && active_src == wdt_pkg::src_low_power_rc_osc;
            secondary_osc_enable <= enabled && active_src == wdt_pkg::src_secondary_osc;
            system_timer_enable <= enabled && active_src == wdt_pkg::src_systimer;
        end
    end

    assign sleep_active = power_state == wdt_pkg::pm_sleep;
    assign idle_active = power_state == wdt_pkg::pm_idle;

    // apb access
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_config_word <= `WDT_CFG_RESET;
            clk_select <= wdt_pkg::src_low_power_rc_osc;
        end else if (wr_access && paddr == `WDT_OFS_CONFIG) begin
            watchdog_config_word <= pwdata[7:0];
        end else if (wr_access && paddr == `WDT_OFS_CLK_SEL) begin
            clk_select <= (pwdata[1:0] == 2'h1) ? wdt_pkg::src_secondary_osc :
                          (pwdata[1:0] == 2'h2) ? wdt_pkg::src_systimer : wdt_pkg::src_low_power_rc_osc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_enable_bit <= 1'b0;
        end else if (any_dev_reset) begin
            soft_enable_bit <= 1'b0;
        end else if (wr_access && paddr == `WDT_OFS_RESET_CTRL) begin
            soft_enable_bit <= pwdata[`WDT_RC_SWEN_BIT];
        end
    end

    // sticky status bits: hardware set wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag <= 1'b0;
            sleep_status <= 1'b0;
            idle_status <= 1'b0;
        end else begin
            if (timeout || early_clear) begin
                timeout_flag <= 1'b1;
            end else if (wr_access && paddr == `WDT_OFS_RESET_CTRL) begin
                timeout_flag <= pwdata[`WDT_RC_FLAG_BIT];
            end
            if (enter_save && core_events.save_to_sleep) begin
                sleep_status <= 1'b1;
            end else if (wr_access && paddr == `WDT_OFS_RESET_CTRL) begin
                sleep_status <= pwdata[`WDT_RC_SLEEP_BIT];
            end
            if (enter_save && !core_events.save_to_sleep) begin
                idle_status <= 1'b1;
            end else if (wr_access && paddr == `WDT_OFS_RESET_CTRL) begin
                idle_status <= pwdata[`WDT_RC_IDLE_BIT];
            end
        end
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            pslverr <= 1'b0;
            if (paddr == `WDT_OFS_CONFIG) begin
                prdata <= {24'h0, watchdog_config_word};
            end else if (paddr == `WDT_OFS_RESET_CTRL) begin
                prdata <= {26'h0, soft_enable_bit, timeout_flag, sleep_status,
                           idle_status, 2'h0};
            end else if (paddr == `WDT_OFS_CLK_SEL) begin
                prdata <= {30'h0, clk_select};
            end else if (paddr == `WDT_OFS_COUNT) begin
                prdata <= {9'h0, count};
            end else begin
                prdata <= 32'h0;
                pslverr <= 1'b1;
            end
        end
    end

    // checks
    sequence s_run_timeout;
        enabled && tick && terminal && !in_save;
    endsequence

    sequence s_save_timeout;
        enabled && tick && terminal && in_save;
    endsequence

    a_run_timeout_reset: assert property (@(posedge pclk) disable iff (!presetn)
        s_run_timeout |=> watchdog_reset && timeout_flag)
        else $error("run time-out did not reset");

    a_save_timeout_wake: assert property (@(posedge pclk) disable iff (!presetn)
        s_save_timeout |=> watchdog_wake && !watchdog_reset && power_state == wdt_pkg::pm_run)
        else $error("power-save time-out did not wake");

    a_flag_stays_set: assert property (@(posedge pclk) disable iff (!presetn)
        timeout_flag && !(wr_access && paddr == `WDT_OFS_RESET_CTRL) |=> timeout_flag)
        else $error("time-out flag dropped without software");

    a_early_clear_reset: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.clear_counter_instr && !in_save && enabled && !window_disable_bit &&
        count < (period - (period >> 2)) |=> watchdog_reset)
        else $error("early clear in window mode did not reset");

    a_off_no_count: assert property (@(posedge pclk) disable iff (!presetn)
        enable_config_field == 2'h0 && !counter_clear |=> $stable(count))
        else $error("disabled watchdog counted");

    a_soft_enable_reset: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.device_reset |=> !soft_enable_bit ##1 !low_power_rc_osc_enable ||
        enable_config_field == 2'h3)
        else $error("device reset kept software enable");

    a_sleep_uses_rc: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_active && enabled |=> low_power_rc_osc_enable || !$past(sleep_active))
        else $error("sleep did not force rc source");

    a_save_clears: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.power_save_instr && !in_save |=> count == '0 && in_save)
        else $error("power-save entry did not clear count");

    a_switch_clears: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.clock_switch_done |=> count == '0)
        else $error("clock switch did not clear count");

    a_count_bounded: assert property (@(posedge pclk) disable iff (!presetn)
        enabled && $stable(watchdog_config_word) |-> count < period)
        else $error("count passed programmed period");

    sequence s_sleep_entry;
        core_events.power_save_instr && core_events.save_to_sleep && !in_save &&
        !core_events.device_reset;
    endsequence

    a_sleep_entry_marks: assert property (@(posedge pclk) disable iff (!presetn)
        s_sleep_entry |=> sleep_active && sleep_status)
        else $error("sleep entry not recorded");

    a_source_enable_on: assert property (@(posedge pclk) disable iff (!presetn)
        enabled |=> low_power_rc_osc_enable || secondary_osc_enable || system_timer_enable)
        else $error("enabled watchdog left its source off");

    a_save_keeps_counting: assert property (@(posedge pclk) disable iff (!presetn)
        enabled && tick && in_save && !counter_clear && !terminal |=>
        count == $past(count) + `WDT_CNT_W'(1))
        else $error("count stalled in power-save");

    a_reset_clears_all: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.device_reset |=> count == '0 && power_state == wdt_pkg::pm_run)
        else $error("device reset did not clear count");

    a_wake_clears: assert property (@(posedge pclk) disable iff (!presetn)
        in_save && core_events.wake_event |=> count == '0 && !in_save)
        else $error("leaving power-save did not clear count");

    a_good_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.clear_counter_instr && !in_save && (window_disable_bit || window_open)
        |=> count == '0)
        else $error("permitted clear did not clear count");

    a_open_clear_safe: assert property (@(posedge pclk) disable iff (!presetn)
        core_events.clear_counter_instr && window_disable_bit && !(enabled && tick && terminal)
        |=> !watchdog_reset)
        else $error("clear with window off caused reset");

    a_soft_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
        enable_config_field == `WDT_EN_SOFT && !soft_enable_bit && !counter_clear
        |=> $stable(count))
        else $error("software-disabled watchdog counted");

    a_always_on_counts: assert property (@(posedge pclk) disable iff (!presetn)
        enable_config_field == `WDT_EN_ALWAYS && tick && !counter_clear |=> $changed(count))
        else $error("always-on watchdog missed a tick");

    a_base_period_ok: assert property (@(posedge pclk) disable iff (!presetn)
        period_of(1'h0, 4'h0) == `WDT_CNT_W'(`WDT_SRC_CLK_KHZ * `WDT_BASE_SHORT_MS) &&
        period_of(1'h1, 4'h0) == `WDT_CNT_W'(`WDT_SRC_CLK_KHZ * `WDT_BASE_LONG_MS))
        else $error("base period does not match source rate");

    a_period_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(period))
        else $error("period is not a power of two");
endmodule

// ### tb/wdt_core_model.sv
// core model: turns bench requests into one-cycle core event pulses
// assumes requests arrive on pclk, one at a time
`timescale 1ns/1ps
module wdt_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic op_go,
    input wire logic [2:0] op,
    input wire logic sleep_active,
    input wire logic idle_active,
    output wdt_pkg::core_events_t core_events
);
    logic run;
    wdt_pkg::core_events_t code;
    assign run = !(sleep_active | idle_active);
    always_comb begin
        case (op)
            3'h0: code = 6'h20;
            3'h1: code = 6'h18;
            3'h2: code = 6'h10;
            3'h3: code = 6'h04;
            3'h4: code = 6'h02;
            default: code = 6'h01;
        endcase
    end
    // a halted core issues no instructions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_events <= '0;
        end else begin
            core_events <= (op_go && (run || op > 3'h2)) ? code : '0;
        end
    end
endmodule

// ### tb/windowed_watchdog_timer_test.sv
// self-checking bench: apb master, core model, slow source clocks
// assumes the watchdog package is compiled first
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
    logic pclk, presetn, psel, penable, pwrite, op_go, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, rc_en, sec_en, sys_en, watchdog_reset, watchdog_wake;
    logic sleep_active, idle_active;
    logic [2:0] op;
    logic [4:0] div = 5'h00;
    logic [7:0] cfg [3] = '{8'he0, 8'he1, 8'hf0};
    wdt_pkg::core_events_t core_events;
    wdt_pkg::wdt_clocks_t src = '0;
    int err_total = 0;
    int checked = 0;
    int rst_n = 0;
    int n, k, m;

    windowed_watchdog_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_events(core_events),
        .src_clocks(src), .low_power_rc_osc_enable(rc_en), .secondary_osc_enable(sec_en),
        .system_timer_enable(sys_en), .watchdog_reset(watchdog_reset),
        .watchdog_wake(watchdog_wake), .sleep_active(sleep_active),
        .idle_active(idle_active));
    wdt_core_model i_core (.pclk(pclk), .presetn(presetn), .op_go(op_go), .op(op),
        .sleep_active(sleep_active), .idle_active(idle_active), .core_events(core_events));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        div <= div + 5'h01;
        src <= {div[2], div[3], div[4]};
        if (watchdog_reset === 1'b1) rst_n <= rst_n + 1;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            $display("FAIL %0t no ready from slave", $time);
            err_total++;
            stop_test;
        end
        @(posedge pclk);
    endtask
    task automatic ev(input logic [2:0] c);
        op <= c;
        op_go <= 1'b1;
        @(posedge pclk);
        op_go <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic wait_out(input int lim);
        n = 0;
        while (watchdog_reset !== 1'b1 && watchdog_wake !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            $display("FAIL %0t no time-out event", $time);
            err_total++;
            stop_test;
        end
    endtask
    function automatic int per(input logic [7:0] c);
        return (c[4] ? 128 : 32) << c[3:0];
    endfunction
    // rc source clock period is 8 pclk (secondary 16, system timer 32); allow one tick of phase and the synchroniser
    task automatic span(input logic [7:0] c);
        chk(n >= (per(c) - 1) * 8 - 8 && n <= per(c) * 8 + 16, 1'b1);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        op = 3'h0;
        op_go = 1'b0;
        void'($urandom(92));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'hff);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({q[30:0], err}, 32'h1);
        foreach (cfg[i]) begin
            apb(1'b1, 12'h000, {24'h0, cfg[i]});
            ev(3'h4);
            wait_out(per(cfg[i]) * 8 + 40);
            span(cfg[i]);
            chk(watchdog_reset, 1'b1);
            apb(1'b0, 12'h004, 32'h0);
            chk(q, 32'h10);
            apb(1'b1, 12'h004, 32'h0);
        end
        apb(1'b1, 12'h000, 32'he0);
        ev(3'h4);
        repeat ($urandom_range(180, 100)) @(posedge pclk);
        ev(3'h0);
        wait_out(400);
        span(8'he0);
        apb(1'b1, 12'h000, 32'h60);
        ev(3'h4);
        repeat (60) @(posedge pclk);
        ev(3'h0);
        wait_out(10);
        chk(watchdog_reset, 1'b1);
        repeat (210) @(posedge pclk);
        ev(3'h0);
        wait_out(400);
        span(8'h60);
        apb(1'b1, 12'h000, 32'h80);
        apb(1'b1, 12'h004, 32'h20);
        m = rst_n;
        repeat (400) @(posedge pclk);
        chk(rst_n - m, 0);
        apb(1'b1, 12'h000, 32'hc0);
        wait_out(400);
        chk(watchdog_reset, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h10);
        m = rst_n;
        repeat (400) @(posedge pclk);
        chk(rst_n - m, 0);
        apb(1'b1, 12'h004, 32'h20);
        ev(3'h5);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h000, 32'he0);
        repeat (2) @(posedge pclk);
        chk({rc_en, sec_en, sys_en}, 3'b001);
        ev(3'h1);
        repeat (2) @(posedge pclk);
        chk({rc_en, sys_en, sleep_active}, 3'b101);
        wait_out(400);
        chk({watchdog_wake, watchdog_reset}, 2'b10);
        span(8'he0);
        repeat (2) @(posedge pclk);
        chk(sleep_active, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h18);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        ev(3'h2);
        repeat (150) @(posedge pclk);
        chk(idle_active, 1'b1);
        ev(3'h3);
        wait_out(400);
        span(8'he0);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(q, 32'h1);
        chk({rc_en, sec_en, sys_en}, 3'b010);
        ev(3'h4);
        apb(1'b0, 12'h00c, 32'h0);
        chk(q <= 1, 1'b1);
        apb(1'b1, 12'h000, 32'ha0);
        m = rst_n;
        repeat (600) @(posedge pclk);
        chk(rst_n - m, 0);
        stop_test;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        $display("FAIL %0t run limit reached", $time);
        err_total++;
        stop_test;
    end
endmodule
